/* File: azs_ctrl.sv */
// Offset auto-zero sequencer driving the result, trim and switch ports
`include "azs_params.svh"

module azs_ctrl (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       start_in,
    input  wire logic       conv_done_n_in,
    input  wire logic [7:0] io_rdata_in,
    output logic      [7:0] io_addr_out,
    output logic      [7:0] io_wdata_out,
    output logic            io_wr_out,
    output logic            io_rd_out,
    output logic            busy_out,
    output logic            done_out,
    output logic      [7:0] trim_code_out,
    output logic      [7:0] sw_ctrl_out
);
    import azs_pkg::*;

    // ****************************************
    // State
    // ****************************************
    azs_regs_t   r_reg;
    azs_regs_t   r_next;
    azs_step_if  #(.W(8)) stp ();

    azs_sar_step #(.W(8)) u_step (
        .s (stp.step)
    );

    assign stp.code   = r_reg.code;
    assign stp.ptr    = r_reg.ptr;
    assign stp.result = r_reg.result;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        r_next       = r_reg;
        r_next.io_wr = 1'b0;
        r_next.io_rd = 1'b0;
        case (r_reg.st)
            AZS_RSTSW: begin
                // Select the signal path before anything else happens
                r_next.sw       = `AZS_SW_SIGNAL;
                r_next.io_addr  = `AZS_ADDR_SWITCH;
                r_next.io_wdata = azs_inv(`AZS_SW_SIGNAL);
                r_next.io_wr    = 1'b1;
                r_next.st       = AZS_IDLE;
            end
            AZS_IDLE: begin
                if (start_in) begin
                    r_next.done = 1'b0;
                    r_next.busy = 1'b1;
                    r_next.st   = AZS_CFG;
                end
            end
            AZS_CFG: begin
                // Control word goes to the port unit itself, unbuffered
                r_next.io_addr  = `AZS_ADDR_CONFIG;
                r_next.io_wdata = `AZS_CFG_WORD;
                r_next.io_wr    = 1'b1;
                r_next.st       = AZS_SWZ;
            end
            AZS_SWZ: begin
                r_next.sw       = `AZS_SW_ZERO;
                r_next.io_addr  = `AZS_ADDR_SWITCH;
                r_next.io_wdata = azs_inv(`AZS_SW_ZERO);
                r_next.io_wr    = 1'b1;
                r_next.st       = AZS_INIT;
            end
            AZS_INIT: begin
                r_next.ptr  = `AZS_PTR_INIT;
                r_next.code = `AZS_CODE_INIT;
                r_next.st   = AZS_OUTB;
            end
            AZS_OUTB: begin
                // Each bit drives one weighted trim resistor
                r_next.io_addr  = `AZS_ADDR_TRIM;
                r_next.io_wdata = azs_inv(r_reg.code);
                r_next.io_wr    = 1'b1;
                r_next.st       = AZS_START;
            end
            AZS_START: begin
                r_next.io_addr  = `AZS_ADDR_RESULT;
                r_next.io_wdata = `AZS_ZERO_BYTE;
                r_next.io_wr    = 1'b1;
                r_next.st       = AZS_WAIT;
            end
            AZS_WAIT: begin
                if (!conv_done_n_in) begin
                    r_next.io_addr = `AZS_ADDR_RESULT;
                    r_next.io_rd   = 1'b1;
                    r_next.st      = AZS_READ;
                end
            end
            AZS_READ: begin
                r_next.result = azs_inv(io_rdata_in);
                r_next.st     = AZS_DECIDE;
            end
            AZS_DECIDE: begin
                r_next.code = stp.code_next;
                r_next.ptr  = stp.ptr_next;
                if (stp.last) begin
                    r_next.st = AZS_FOUT;
                end else begin
                    r_next.st = AZS_OUTB;
                end
            end
            AZS_FOUT: begin
                r_next.io_addr  = `AZS_ADDR_TRIM;
                r_next.io_wdata = azs_inv(r_reg.code);
                r_next.io_wr    = 1'b1;
                r_next.st       = AZS_FIN;
            end
            AZS_FIN: begin
                // Open the zero switch, close the signal switch
                r_next.sw       = r_reg.sw ^ `AZS_SW_TOGGLE;
                r_next.io_addr  = `AZS_ADDR_SWITCH;
                r_next.io_wdata = azs_inv(r_reg.sw ^ `AZS_SW_TOGGLE);
                r_next.io_wr    = 1'b1;
                r_next.trim     = r_reg.code;
                r_next.done     = 1'b1;
                r_next.busy     = 1'b0;
                r_next.st       = AZS_IDLE;
            end
            default: begin
                r_next.st = AZS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r_reg.st       <= AZS_RSTSW;
            r_reg.code     <= `AZS_CODE_INIT;
            r_reg.ptr      <= `AZS_ZERO_BYTE;
            r_reg.result   <= `AZS_ZERO_BYTE;
            r_reg.sw       <= `AZS_SW_SIGNAL;
            r_reg.io_addr  <= `AZS_ZERO_BYTE;
            r_reg.io_wdata <= `AZS_ZERO_BYTE;
            r_reg.io_wr    <= 1'b0;
            r_reg.io_rd    <= 1'b0;
            r_reg.busy     <= 1'b0;
            r_reg.done     <= 1'b0;
            r_reg.trim     <= `AZS_CODE_INIT;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign io_addr_out   = r_reg.io_addr;
    assign io_wdata_out  = r_reg.io_wdata;
    assign io_wr_out     = r_reg.io_wr;
    assign io_rd_out     = r_reg.io_rd;
    assign busy_out      = r_reg.busy;
    assign done_out      = r_reg.done;
    assign trim_code_out = r_reg.trim;
    assign sw_ctrl_out   = r_reg.sw;

    // ****************************************
    // Checks
    // ****************************************
    logic [3:0] step_cnt_reg;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            step_cnt_reg <= 4'h0;
        end else if (r_reg.st == AZS_INIT) begin
            step_cnt_reg <= 4'h0;
        end else if (r_reg.st == AZS_DECIDE) begin
            step_cnt_reg <= step_cnt_reg + 4'h1;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_trim_write;
        io_wr_out && io_addr_out == `AZS_ADDR_TRIM;
    endsequence

    sequence s_conv_start;
        io_wr_out && io_addr_out == `AZS_ADDR_RESULT;
    endsequence

    property p_addr_map;
        io_wr_out |-> io_addr_out inside {`AZS_ADDR_RESULT, `AZS_ADDR_TRIM,
                                          `AZS_ADDR_SWITCH, `AZS_ADDR_CONFIG};
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("write outside port map");

    property p_cfg;
        io_wr_out && io_addr_out == `AZS_ADDR_CONFIG |-> io_wdata_out == `AZS_CFG_WORD;
    endproperty
    a_cfg: assert property (p_cfg) else $error("bad configuration word");

    property p_read_port;
        io_rd_out |-> io_addr_out == `AZS_ADDR_RESULT && !io_wr_out;
    endproperty
    a_read_port: assert property (p_read_port) else $error("read of output port");

    property p_sw_opposite;
        io_wr_out && io_addr_out == `AZS_ADDR_SWITCH
            |-> io_wdata_out[0] != io_wdata_out[1] && sw_ctrl_out[0] != sw_ctrl_out[1];
    endproperty
    a_sw_opposite: assert property (p_sw_opposite) else $error("switches not opposite");

    property p_zero_first;
        io_wr_out && io_addr_out == `AZS_ADDR_CONFIG
            |=> io_wr_out && io_addr_out == `AZS_ADDR_SWITCH
                && io_wdata_out == azs_inv(`AZS_SW_ZERO);
    endproperty
    a_zero_first: assert property (p_zero_first) else $error("zero switch not closed");

    property p_init;
        r_reg.st == AZS_INIT |=> r_reg.ptr == `AZS_PTR_INIT && r_reg.code == `AZS_CODE_INIT;
    endproperty
    a_init: assert property (p_init) else $error("bad initial pointer or code");

    property p_step_order;
        s_trim_write ##1 s_conv_start |=> !io_wr_out && !io_rd_out;
    endproperty
    a_step_order: assert property (p_step_order) else $error("bus busy during wait");

    property p_rd_after_done;
        $rose(io_rd_out) |-> !$past(conv_done_n_in);
    endproperty
    a_rd_after_done: assert property (p_rd_after_done) else $error("read before done");

    property p_clear;
        r_reg.st == AZS_DECIDE && r_reg.result == `AZS_ZERO_BYTE
            |=> r_reg.code == ($past(r_reg.code) & ~$past(r_reg.ptr));
    endproperty
    a_clear: assert property (p_clear) else $error("trial bit not cleared");

    property p_set;
        r_reg.st == AZS_DECIDE && r_reg.result != `AZS_ZERO_BYTE
            |=> r_reg.code == ($past(r_reg.code) | $past(r_reg.ptr));
    endproperty
    a_set: assert property (p_set) else $error("trial bit not set");

    property p_steps;
        $rose(done_out) |-> step_cnt_reg == `AZS_STEPS && r_reg.ptr == `AZS_ZERO_BYTE;
    endproperty
    a_steps: assert property (p_steps) else $error("wrong number of steps");

    property p_finish;
        $rose(done_out) |-> io_wr_out && io_addr_out == `AZS_ADDR_SWITCH
            && sw_ctrl_out == `AZS_SW_SIGNAL && $past(sw_ctrl_out) == `AZS_SW_ZERO;
    endproperty
    a_finish: assert property (p_finish) else $error("switches not toggled");

    property p_hold;
        done_out && !start_in |=> done_out && $stable(trim_code_out);
    endproperty
    a_hold: assert property (p_hold) else $error("final code not held");

    property p_trim_inv;
        s_trim_write |-> io_wdata_out == azs_inv(r_reg.code);
    endproperty
    a_trim_inv: assert property (p_trim_inv) else $error("trim data not inverted code");

    property p_conv_data;
        s_conv_start |-> io_wdata_out == `AZS_ZERO_BYTE;
    endproperty
    a_conv_data: assert property (p_conv_data) else $error("bad conversion start data");

    property p_zeroing_sw;
        r_reg.st inside {AZS_OUTB, AZS_START, AZS_WAIT, AZS_READ, AZS_DECIDE}
            |-> sw_ctrl_out == `AZS_SW_ZERO;
    endproperty
    a_zeroing_sw: assert property (p_zeroing_sw) else $error("zero switch open in run");

    property p_idle_sw;
        !busy_out && !done_out |-> sw_ctrl_out == `AZS_SW_SIGNAL;
    endproperty
    a_idle_sw: assert property (p_idle_sw) else $error("signal switch not selected");

    property p_done_busy;
        done_out |-> !busy_out;
    endproperty
    a_done_busy: assert property (p_done_busy) else $error("done while busy");

endmodule

/* File: azs_params.svh */
// Constants for the offset auto-zero sequencer
`ifndef AZS_PARAMS_SVH
`define AZS_PARAMS_SVH

// ****************************************
// Port addresses
// ****************************************
`define AZS_ADDR_RESULT   8'he4
`define AZS_ADDR_TRIM     8'he5
`define AZS_ADDR_SWITCH   8'he6
`define AZS_ADDR_CONFIG   8'he7

// ****************************************
// Port values
// ****************************************
`define AZS_CFG_WORD      8'h90
`define AZS_PTR_INIT      8'h80
`define AZS_CODE_INIT     8'h7f
`define AZS_SW_ZERO       8'h01
`define AZS_SW_SIGNAL     8'h02
`define AZS_SW_TOGGLE     8'h03
`define AZS_ZERO_BYTE     8'h00
`define AZS_STEPS         4'h8

`endif

/* File: azs_pkg.sv */
// Types and helpers shared by the auto-zero sequencer
package azs_pkg;

    typedef enum logic [3:0] {
        AZS_RSTSW  = 4'b0000,
        AZS_IDLE   = 4'b0001,
        AZS_CFG    = 4'b0010,
        AZS_SWZ    = 4'b0011,
        AZS_INIT   = 4'b0100,
        AZS_OUTB   = 4'b0101,
        AZS_START  = 4'b0110,
        AZS_WAIT   = 4'b0111,
        AZS_READ   = 4'b1000,
        AZS_DECIDE = 4'b1001,
        AZS_FOUT   = 4'b1010,
        AZS_FIN    = 4'b1011
    } azs_state_t;

    typedef struct packed {
        azs_state_t  st;
        logic [7:0]  code;
        logic [7:0]  ptr;
        logic [7:0]  result;
        logic [7:0]  sw;
        logic [7:0]  io_addr;
        logic [7:0]  io_wdata;
        logic        io_wr;
        logic        io_rd;
        logic        busy;
        logic        done;
        logic [7:0]  trim;
    } azs_regs_t;

    // Switch, trim and result data pass through inverting buffers; the config word does not
    function automatic logic [7:0] azs_inv(input logic [7:0] v);
        return ~v;
    endfunction

endpackage

/* File: azs_step_if.sv */
// Carrier between the sequencer and its approximation step unit
interface azs_step_if #(parameter int W = 8);
    logic [W-1:0] code;
    logic [W-1:0] ptr;
    logic [W-1:0] result;
    logic [W-1:0] code_next;
    logic [W-1:0] ptr_next;
    logic         last;

    modport ctrl (output code, output ptr, output result,
                  input code_next, input ptr_next, input last);
    modport step (input code, input ptr, input result,
                  output code_next, output ptr_next, output last);
endinterface

/* File: azs_sar_step.sv */
// One successive-approximation decision on the trim code
module azs_sar_step #(
    parameter int W = 8
) (
    azs_step_if.step s
);
    logic neg;

    always_comb begin
        // A zero result means the preamp output is negative
        neg = (s.result == '0);
        if (neg) begin
            s.code_next = s.code & ~s.ptr;
        end else begin
            s.code_next = s.code | s.ptr;
        end
        s.ptr_next = s.ptr >> 1;
        s.last     = (s.ptr_next == '0);
    end
endmodule

/* File: azs_conv_model.sv */
// Converter, preamp and switch network model on the far side of the port bus
`include "azs_params.svh"
module azs_conv_model (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] io_addr_in,
    input  wire logic [7:0] io_wdata_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] offset_in,
    input  wire logic [7:0] delay_in,
    output logic            conv_done_n_out,
    output logic      [7:0] io_rdata_out,
    output logic      [7:0] sw_out,
    output logic      [7:0] trim_out,
    output logic      [7:0] cfg_out,
    output logic      [3:0] conv_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] res_q;
    logic [7:0] wait_q;
    logic [7:0] noise_q;
    logic       conv_q;
    logic       rd_res;
    assign rd_res = io_rd_in && io_addr_in == `AZS_ADDR_RESULT;
    // Unread data lines carry a pattern that changes every cycle
    assign io_rdata_out = rd_res ? ~res_q : noise_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {res_q, wait_q, noise_q, sw_out, trim_out, cfg_out} <= '0;
            conv_q <= 1'b0;
            conv_cnt_out <= 4'h0;
            conv_done_n_out <= 1'b1;
        end else begin
            noise_q <= noise_q + 8'h35;
            if (io_wr_in) begin
                case (io_addr_in)
                    `AZS_ADDR_CONFIG: begin
                        cfg_out <= io_wdata_in;
                        conv_cnt_out <= 4'h0;
                    end
                    `AZS_ADDR_SWITCH: sw_out <= ~io_wdata_in;
                    `AZS_ADDR_TRIM: trim_out <= ~io_wdata_in;
                    `AZS_ADDR_RESULT: begin
                        // Higher trim pushes the output down; negative reads as zero
                        res_q <= (trim_out < offset_in) ? offset_in - trim_out : 8'h00;
                        wait_q <= delay_in;
                        conv_q <= 1'b1;
                        conv_cnt_out <= conv_cnt_out + 4'h1;
                    end
                    default: ;
                endcase
            end
            if (conv_q) begin
                if (wait_q == 8'h00) begin
                    conv_done_n_out <= 1'b0;
                    conv_q <= 1'b0;
                end else begin
                    wait_q <= wait_q - 8'h01;
                end
            end
            if (rd_res) begin
                conv_done_n_out <= 1'b1;
            end
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the offset auto-zero sequencer
`include "azs_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk_in, rst_in, start_in, conv_done_n, io_wr, io_rd, busy, done;
    logic [7:0] io_rdata, io_addr, io_wdata, trim_code, sw_ctrl;
    logic [7:0] m_sw, m_trim, m_cfg, offset, delay;
    logic [3:0] conv_cnt;
    int         err_total, compares;

    azs_ctrl dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .start_in(start_in),
        .conv_done_n_in(conv_done_n), .io_rdata_in(io_rdata), .io_addr_out(io_addr),
        .io_wdata_out(io_wdata), .io_wr_out(io_wr), .io_rd_out(io_rd), .busy_out(busy),
        .done_out(done), .trim_code_out(trim_code), .sw_ctrl_out(sw_ctrl));
    azs_conv_model model_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .io_addr_in(io_addr),
        .io_wdata_in(io_wdata), .io_wr_in(io_wr), .io_rd_in(io_rd), .offset_in(offset),
        .delay_in(delay), .conv_done_n_out(conv_done_n), .io_rdata_out(io_rdata),
        .sw_out(m_sw), .trim_out(m_trim), .cfg_out(m_cfg), .conv_cnt_out(conv_cnt));

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Trim code that the bit-by-bit search must settle on
    function automatic logic [7:0] exp_code(input logic [7:0] off);
        logic [7:0] code;
        logic [7:0] ptr;
        code = `AZS_CODE_INIT;
        ptr = `AZS_PTR_INIT;
        repeat (8) begin
            code = (code >= off) ? (code & ~ptr) : (code | ptr);
            ptr = ptr >> 1;
        end
        return code;
    endfunction

    // ****************************************
    // One zeroing run
    // ****************************************
    task automatic run_zero(input logic [7:0] off, input logic [7:0] dly);
        int n;
        logic [7:0] exp;
        exp = exp_code(off);
        offset <= off;
        delay <= dly;
        start_in <= 1'b1;
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        n = 0;
        while (conv_cnt !== 4'h1 && n < 500) begin
            @(posedge sys_clk_in);
            n++;
        end
        check8({4'h0, conv_cnt}, 8'h01, "first conversion");
        check8({6'h0, busy, done}, 8'h02, "busy in run");
        check8(m_cfg, `AZS_CFG_WORD, "config word");
        check8(m_sw, `AZS_SW_ZERO, "switch port in run");
        check8(sw_ctrl, `AZS_SW_ZERO, "switch state in run");
        check8(m_trim, `AZS_CODE_INIT, "first trial code");
        // A second request in mid-run must not restart the search
        start_in <= 1'b1;
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_in);
            n++;
        end
        @(posedge sys_clk_in);
        check8({7'h0, done}, 8'h01, "done");
        check8({4'h0, conv_cnt}, {4'h0, `AZS_STEPS}, "conversions");
        check8(trim_code, exp, "final code");
        check8(m_trim, exp, "trim port");
        check8(m_sw, `AZS_SW_SIGNAL, "switch port after");
        check8(sw_ctrl, `AZS_SW_SIGNAL, "switch state after");
        repeat (5) @(posedge sys_clk_in);
        check8({6'h0, busy, done}, 8'h01, "done held");
        check8(trim_code, exp, "code held");
        $display("Test offset %h delay %h finished", off, dly);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_in = 1'b1;
        start_in = 1'b0;
        offset = 8'h00;
        delay = 8'h00;
        err_total = 0;
        compares = 0;
        repeat (2) @(posedge sys_clk_in);
        check8(trim_code, `AZS_CODE_INIT, "reset code");
        check8(sw_ctrl, `AZS_SW_SIGNAL, "reset switch");
        check8({6'h0, busy, done}, 8'h00, "reset flags");
        rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        check8(m_sw, `AZS_SW_SIGNAL, "idle switch port");
        check8({4'h0, conv_cnt}, 8'h00, "no conversion when idle");
        $display("Test reset finished");
        run_zero(8'h00, 8'h00);
        run_zero(8'hff, 8'h03);
        run_zero(8'h80, 8'h14);
        run_zero(8'h5a, 8'h01);
        run_zero(8'h7f, 8'h00);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_total++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
